/* File: test/wdt_sys_model.sv */
/*
  wdt_sys_model: stand-in for what sits beyond the watchdog, namely the
  interrupt controller, the debugger's halt line and the system reset logic.
  Assumes it shares aclk and aresetn with the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module wdt_sys_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // watchdog outputs
  input wire logic irq,
  input wire logic sys_reset_req,
  // debugger command and what the system saw
  input wire logic halt_req,
  output logic dbg_halt,
  output logic rst_seen,
  output logic irq_seen
);
  // controller notes that the interrupt line was raised since the last reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_seen <= 1'h0;
    end else if (irq) begin
      irq_seen <= 1'h1;
    end
  end

  // halt lands a cycle after the debugger asks, as a synchronised request would
  always_ff @(posedge aclk) begin
    dbg_halt <= halt_req;
  end

  // reset logic latches the request; only a system reset takes it back
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_seen <= 1'h0;
    end else if (sys_reset_req) begin
      rst_seen <= 1'h1;
    end
  end
endmodule // wdt_sys_model
`default_nettype wire

/* File: test/wdt_top_bench.sv */
/*
  wdt_top_bench: self-checking bench for wdt_top, driving the AXI4-Lite
  register bus. Assumes the register map and reset values of wdt_pkg.
*/
`timescale 1ns/1ps
`default_nettype none
module wdt_top_bench import wdt_pkg::*;;
  // clock, reset and bus signals
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic halt_req = 1'h0;
  logic dbg_halt, irq, sys_reset_req, rst_seen, irq_seen;
  int checked = 0;
  int n_mismatch = 0;
  int cycles = 0;

  // 200 MHz clock
  always #2.5 aclk = ~aclk;

  wdt_top wdt_top_inst (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .dbg_halt(dbg_halt), .irq(irq), .sys_reset_req(sys_reset_req)
  );

  wdt_sys_model wdt_sys_model_inst (
    .aclk(aclk), .aresetn(aresetn), .irq(irq), .sys_reset_req(sys_reset_req),
    .halt_req(halt_req), .dbg_halt(dbg_halt), .rst_seen(rst_seen), .irq_seen(irq_seen)
  );

  task automatic results;
    $display("counts: checked=%0d mismatches=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // a hang is cut short well past the few hundred cycles the tests need
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      results();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // write: address and data offered together, each dropped once taken
  // waits for the answer however long it takes; only the bench timeout cuts a hang
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (!(bvalid && bready));
    resp = bresp;
    bready <= 1'h0;
    // spare edge so the next call never re-drives bready in this step
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
    end while (!(rvalid && rready));
    d = rdata;
    resp = rresp;
    rready <= 1'h0;
    @(posedge aclk);
  endtask

  task automatic w(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
  endtask

  task automatic chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    logic [1:0] r;
    rd(a, v, r);
    check(v, exp);
  endtask

  // counter reads drift with bus latency, so only a window is checked
  task automatic rng(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi);
    logic [31:0] v;
    logic [1:0] r;
    rd(a, v, r);
    check({31'h0, v >= lo && v <= hi}, 32'h1);
  endtask

  // wait for irq (sel 0) or the reset request (sel 1) under a bound
  task automatic wait_hi(input logic sel, input int lim);
    int n;
    n = 0;
    while ((sel ? sys_reset_req : irq) !== 1'h1 && n < lim) begin
      @(posedge aclk);
      n++;
    end
    check({31'h0, sel ? sys_reset_req : irq}, 32'h1);
  endtask

  task automatic do_reset;
    aresetn <= 1'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
  endtask

  // main sequence
  initial begin
    logic [31:0] v, v2;
    logic [1:0] r;
    do_reset();
    chk(WDT_LOAD_OFS, WDT_LOAD_RST);
    chk(WDT_VALUE_OFS, WDT_LOAD_RST);
    chk(WDT_CTRL_OFS, 32'h0);
    chk(WDT_RIS_OFS, 32'h0);
    chk(WDT_LOCK_OFS, 32'h0);
    check({31'h0, irq_seen}, 32'h0);
    rd(8'h40, v, r);
    check(v, 32'h0);
    check({30'h0, r}, {30'h0, WDT_RESP_SLVERR});
    wr(8'h40, 32'h1, r);
    check({30'h0, r}, {30'h0, WDT_RESP_SLVERR});
    $display("test reset_values done");
    // first timeout, reload, and no reset while the option is off
    w(WDT_LOAD_OFS, 32'h28);
    chk(WDT_VALUE_OFS, 32'h28);
    w(WDT_CTRL_OFS, 32'h1);
    rd(WDT_VALUE_OFS, v, r);
    rd(WDT_VALUE_OFS, v2, r);
    check({31'h0, v2 < v}, 32'h1);
    wait_hi(1'h0, 60);
    chk(WDT_RIS_OFS, 32'h1);
    chk(WDT_MIS_OFS, 32'h1);
    check({31'h0, irq_seen}, 32'h1);
    rng(WDT_VALUE_OFS, 32'h14, 32'h28);
    repeat (100) @(posedge aclk);
    check({31'h0, sys_reset_req}, 32'h0);
    $display("test first_timeout done");
    // the handler clears first thing, so the source is gone before it returns
    w(WDT_INTCLR_OFS, 32'h0);
    repeat (2) @(posedge aclk);
    check({31'h0, irq}, 32'h0);
    chk(WDT_RIS_OFS, 32'h0);
    rng(WDT_VALUE_OFS, 32'h14, 32'h28);
    w(WDT_LOAD_OFS, 32'h3E8);
    rng(WDT_VALUE_OFS, 32'h3D4, 32'h3E8);
    $display("test clear_reload done");
    // lock blocks every configuration write, unlock restores them
    w(WDT_LOCK_OFS, 32'h0);
    chk(WDT_LOCK_OFS, 32'h1);
    w(WDT_LOAD_OFS, 32'h5);
    chk(WDT_LOAD_OFS, 32'h3E8);
    w(WDT_CTRL_OFS, 32'h6);
    chk(WDT_CTRL_OFS, 32'h1);
    w(WDT_EVT_MASK_OFS, 32'h3);
    chk(WDT_EVT_MASK_OFS, 32'h0);
    w(WDT_LOCK_OFS, WDT_UNLOCK_KEY);
    chk(WDT_LOCK_OFS, 32'h0);
    w(WDT_LOAD_OFS, 32'h0);
    chk(WDT_RIS_OFS, 32'h1);
    chk(WDT_LOAD_OFS, 32'h0);
    $display("test lock done");
    // second timeout with the interrupt still pending and reset enabled
    w(WDT_CTRL_OFS, 32'h3);
    wait_hi(1'h1, 20);
    chk(WDT_EVT_STAT_OFS, 32'h3);
    chk(WDT_EVT_STAT_OFS, 32'h0);
    check({31'h0, rst_seen}, 32'h1);
    do_reset();
    check({31'h0, sys_reset_req}, 32'h0);
    chk(WDT_CTRL_OFS, 32'h0);
    $display("test system_reset done");
    // enable refused under lock; event mask drives irq while disabled
    w(WDT_LOCK_OFS, 32'h1);
    w(WDT_CTRL_OFS, 32'h1);
    chk(WDT_CTRL_OFS, 32'h0);
    chk(WDT_VALUE_OFS, WDT_LOAD_RST);
    w(WDT_LOCK_OFS, WDT_UNLOCK_KEY);
    w(WDT_EVT_MASK_OFS, 32'h1);
    w(WDT_LOAD_OFS, 32'h0);
    wait_hi(1'h0, 10);
    chk(WDT_MIS_OFS, 32'h0);
    chk(WDT_EVT_STAT_OFS, 32'h1);
    repeat (2) @(posedge aclk);
    check({31'h0, irq}, 32'h0);
    w(WDT_INTCLR_OFS, 32'h0);
    chk(WDT_RIS_OFS, 32'h0);
    $display("test lock_enable_events done");
    // debug stall freezes the count only while halted
    w(WDT_LOAD_OFS, 32'h12C);
    halt_req <= 1'h1;
    w(WDT_CTRL_OFS, 32'h5);
    rd(WDT_VALUE_OFS, v, r);
    repeat (20) @(posedge aclk);
    chk(WDT_VALUE_OFS, v);
    halt_req <= 1'h0;
    repeat (20) @(posedge aclk);
    rd(WDT_VALUE_OFS, v2, r);
    check({31'h0, v2 < v}, 32'h1);
    $display("test debug_stall done");
    results();
  end
endmodule // wdt_top_bench
`default_nettype wire

/* File: verilog/wdt_axil_slave.sv */
/*
  wdt_axil_slave: AXI4-Lite slave front end, one write and one read in flight.
  Assumes the core answers wr_ok, rd_data and rd_ok in the same cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module wdt_axil_slave
  import wdt_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write channels
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read channels
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // core side
  wdt_reg_if.slave rif
);
  logic aw_have_q, w_have_q, ar_have_q;
  logic [7:0] aw_addr_q, ar_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;

  // next slot and answer state; readies are registered from it so they leave a flop
  wire aw_have_d = !rif.wr_en && (aw_have_q || (awvalid && awready));
  wire w_have_d = !rif.wr_en && (w_have_q || (wvalid && wready));
  wire bvalid_d = rif.wr_en || (bvalid && !bready);
  wire ar_have_d = !rif.rd_en && (ar_have_q || (arvalid && arready));
  wire rvalid_d = rif.rd_en || (rvalid && !rready);
  assign rif.wr_en = aw_have_q && w_have_q && !bvalid;
  assign rif.wr_addr = aw_addr_q;
  assign rif.wr_data = w_data_q;
  assign rif.wr_strb = w_strb_q;
  assign rif.rd_en = ar_have_q && !rvalid;
  assign rif.rd_addr = ar_addr_q;

  // write path: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= WDT_RESP_OKAY;
      awready <= 1'b1;
      wready <= 1'b1;
    end else begin
      // ready only while the slot stays empty and no answer is outstanding
      awready <= !aw_have_d && !bvalid_d;
      wready <= !w_have_d && !bvalid_d;
      if (awvalid && awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_have_q <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (rif.wr_en) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid <= 1'b1;
        bresp <= rif.wr_ok ? WDT_RESP_OKAY : WDT_RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // read path: data captured in the cycle the core is asked
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_have_q <= 1'b0;
      ar_addr_q <= 8'h00;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= WDT_RESP_OKAY;
      arready <= 1'b1;
    end else begin
      arready <= !ar_have_d && !rvalid_d;
      if (arvalid && arready) begin
        ar_have_q <= 1'b1;
        ar_addr_q <= araddr;
      end
      if (rif.rd_en) begin
        ar_have_q <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rif.rd_data;
        rresp <= rif.rd_ok ? WDT_RESP_OKAY : WDT_RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  a_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before taken");
  a_rvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data changed before taken");
endmodule // wdt_axil_slave
`default_nettype wire

/* File: verilog/wdt_pkg.sv */
/*
  wdt_pkg: register map, field positions, reset values and phase encoding of
  the two-stage watchdog. Assumes a 32-bit AXI4-Lite register bus.
*/
package wdt_pkg;
  // register byte offsets
  localparam logic [7:0] WDT_LOAD_OFS = 8'h00;
  localparam logic [7:0] WDT_VALUE_OFS = 8'h04;
  localparam logic [7:0] WDT_CTRL_OFS = 8'h08;
  localparam logic [7:0] WDT_INTCLR_OFS = 8'h0C;
  localparam logic [7:0] WDT_RIS_OFS = 8'h10;
  localparam logic [7:0] WDT_MIS_OFS = 8'h14;
  localparam logic [7:0] WDT_LOCK_OFS = 8'h18;
  localparam logic [7:0] WDT_EVT_STAT_OFS = 8'h1C;
  localparam logic [7:0] WDT_EVT_MASK_OFS = 8'h20;
  // control field positions
  localparam int WDT_CTRL_EN_BIT = 0;
  localparam int WDT_CTRL_RSTEN_BIT = 1;
  localparam int WDT_CTRL_STALL_BIT = 2;
  // event status field positions
  localparam int WDT_EVT_TIMEOUT_BIT = 0;
  localparam int WDT_EVT_RESET_BIT = 1;
  localparam int WDT_EVT_W = 2;
  // reset values
  localparam logic [31:0] WDT_LOAD_RST = 32'hFFFF_FFFF;
  localparam logic [WDT_EVT_W-1:0] WDT_EVT_MASK_RST = 2'h0;
  // unlock key, value is arbitrary
  localparam logic [31:0] WDT_UNLOCK_KEY = 32'h5A5A_C3C3;
  // axi responses
  localparam logic [1:0] WDT_RESP_OKAY = 2'h0;
  localparam logic [1:0] WDT_RESP_SLVERR = 2'h2;

  // watchdog phase
  typedef enum logic [3:0] {
    WDT_PH_OFF = 4'b0001,
    WDT_PH_RUN = 4'b0010,
    WDT_PH_PEND = 4'b0100,
    WDT_PH_RST = 4'b1000
  } wdt_phase_t;
endpackage

/* File: verilog/wdt_reg_if.sv */
/*
  wdt_reg_if: one-cycle register access strobes between the AXI4-Lite slave
  and the watchdog core. Assumes both ends share aclk.
*/
`timescale 1ns/1ps
`default_nettype none
interface wdt_reg_if;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic rd_en;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;
  modport slave (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr, input wr_ok, rd_data, rd_ok);
  modport core (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr, output wr_ok, rd_data, rd_ok);
endinterface
`default_nettype wire

/* File: verilog/wdt_top.sv */
/*
  wdt_top: two-stage watchdog with load value, raw and masked interrupt,
  optional system reset on the second timeout and a configuration lock.
  Assumes a single 200 MHz clock, synchronous inputs and an AXI4-Lite master.
*/
`timescale 1ns/1ps
`default_nettype none
// Function
// [RULE_01] a 32-bit down counter runs while enabled and flags a first timeout when it reaches zero.
// [RULE_02] enabling the counter also enables the watchdog interrupt.
// [RULE_03] at the first zero the counter reloads from the load value and keeps counting.
// [RULE_04] a second zero while the interrupt is pending and reset is enabled raises the reset request.
// [RULE_05] clearing the pending interrupt before the second zero reloads the counter and resumes counting.
// [RULE_06] writing a load value while running loads it into the counter at once.
// [RULE_07] the enable command starts counter and interrupt but does nothing while locked.
// [RULE_08] the lock blocks software writes to all configuration registers until released.
// [RULE_09] the lock state reads as one while locked and zero otherwise.
// [RULE_10] clearing the interrupt removes the pending source so the interrupt output falls; a set event bit enabled in the event mask keeps irq up.
// [RULE_11] raw and masked interrupt status are both readable, one when active.
// [RULE_12] software should clear the interrupt early in its handler since the clear takes time to land.
// [RULE_13] releasing the lock restores write access to the configuration registers.
// [RULE_14] a reset enable bit, writable only while unlocked, decides whether the second timeout resets.
// [RULE_15] writing a load value of zero raises the interrupt immediately.
// [RULE_16] with debug stall set the counter halts while the processor is debug-halted.
// [RULE_17] after reset the counter is off, reset option off, lock released and nothing pending.
module wdt_top
  import wdt_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // system side
  input wire logic dbg_halt,
  output logic irq,
  output logic sys_reset_req
);
  wdt_reg_if rif ();

  wdt_axil_slave wdt_axil_slave_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .rif(rif)
  );

  // merge written bytes into an old word under the byte strobes
  function automatic logic [31:0] merge_strb(input logic [31:0] old_w, input logic [31:0] new_w,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_w[8*i +: 8];
      end
    end
    return r;
  endfunction

  wdt_phase_t phase_q, phase_d;
  logic [31:0] count_q, count_d;
  logic [31:0] load_q;
  logic en_q, rsten_q, stall_q, lock_q, irq_q, rst_q;
  logic [WDT_EVT_W-1:0] evt_q, evt_mask_q;

  // address decode
  wire wr_load = rif.wr_en && rif.wr_addr == WDT_LOAD_OFS;
  wire wr_ctrl = rif.wr_en && rif.wr_addr == WDT_CTRL_OFS;
  wire wr_intclr = rif.wr_en && rif.wr_addr == WDT_INTCLR_OFS;
  wire wr_lock = rif.wr_en && rif.wr_addr == WDT_LOCK_OFS;
  wire wr_mask = rif.wr_en && rif.wr_addr == WDT_EVT_MASK_OFS;
  wire rd_evt = rif.rd_en && rif.rd_addr == WDT_EVT_STAT_OFS;
  wire wr_mapped = wr_load || wr_ctrl || wr_intclr || wr_lock || wr_mask;

  // configuration writes pass only while unlocked; refused ones still answer okay
  wire cfg_open = !lock_q; // [RULE_08] [RULE_13]
  wire [31:0] load_wr = merge_strb(load_q, rif.wr_data, rif.wr_strb);
  wire load_upd = wr_load && cfg_open; // [RULE_08]
  wire ctrl_upd = wr_ctrl && cfg_open && rif.wr_strb[0]; // [RULE_08] [RULE_14]
  wire en_set = ctrl_upd && rif.wr_data[WDT_CTRL_EN_BIT]; // [RULE_07]
  wire [31:0] lock_wr = merge_strb(32'h0000_0000, rif.wr_data, rif.wr_strb);

  // counting and timeout detection
  wire tick = en_q && !(stall_q && dbg_halt); // [RULE_16]
  wire at_zero = count_q == 32'h0000_0000;
  wire timeout = tick && at_zero; // [RULE_01]
  wire int_raw = phase_q == WDT_PH_PEND || phase_q == WDT_PH_RST;
  wire int_masked = int_raw && en_q; // [RULE_02] [RULE_11]
  wire zero_load = load_upd && load_wr == 32'h0000_0000;

  // phase and counter next state
  always_comb begin
    phase_d = phase_q;
    count_d = count_q;
    if (tick) begin
      count_d = count_q - 32'h0000_0001; // [RULE_01]
    end
    case (phase_q)
      WDT_PH_OFF: begin
        if (en_set) begin
          phase_d = WDT_PH_RUN; // [RULE_07]
        end
      end
      WDT_PH_RUN: begin
        if (timeout) begin
          phase_d = WDT_PH_PEND;
          count_d = load_q; // [RULE_03]
        end
      end
      WDT_PH_PEND: begin
        if (timeout && rsten_q && !wr_intclr) begin
          phase_d = WDT_PH_RST; // [RULE_04]
          count_d = load_q;
        end else if (timeout) begin
          count_d = load_q; // a clear in this cycle is taken, the new zero re-arms the interrupt
        end else if (wr_intclr) begin
          phase_d = en_q ? WDT_PH_RUN : WDT_PH_OFF; // [RULE_05] [RULE_10]
          count_d = load_q; // [RULE_05]
        end
      end
      WDT_PH_RST: begin
        count_d = count_q; // frozen until the system reset arrives
      end
      default: begin
        phase_d = WDT_PH_OFF;
      end
    endcase
    // a zero load raises the interrupt at once, a nonzero one restarts the count
    if (load_upd && phase_q != WDT_PH_RST) begin
      count_d = load_wr; // [RULE_06]
      if (zero_load) begin
        phase_d = WDT_PH_PEND; // [RULE_15]
      end
    end
  end

  // watchdog state registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_q <= WDT_PH_OFF; // [RULE_17]
      count_q <= WDT_LOAD_RST;
    end else begin
      phase_q <= phase_d;
      count_q <= count_d;
    end
  end

  // configuration registers; enable can only be set, reset clears it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      load_q <= WDT_LOAD_RST;
      en_q <= 1'b0; // [RULE_17]
      rsten_q <= 1'b0;
      stall_q <= 1'b0;
      lock_q <= 1'b0;
      evt_mask_q <= WDT_EVT_MASK_RST;
    end else begin
      if (load_upd) begin
        load_q <= load_wr;
      end
      if (en_set) begin
        en_q <= 1'b1; // [RULE_02] [RULE_07]
      end
      if (ctrl_upd) begin
        rsten_q <= rif.wr_data[WDT_CTRL_RSTEN_BIT]; // [RULE_14]
        stall_q <= rif.wr_data[WDT_CTRL_STALL_BIT];
      end
      if (wr_lock) begin
        lock_q <= lock_wr != WDT_UNLOCK_KEY; // [RULE_08] [RULE_13]
      end
      if (wr_mask && cfg_open && rif.wr_strb[0]) begin
        evt_mask_q <= rif.wr_data[WDT_EVT_W-1:0];
      end
    end
  end

  // sticky event bits, cleared by reading; a new event in the read cycle wins
  wire [WDT_EVT_W-1:0] evt_new = {phase_d == WDT_PH_RST && phase_q != WDT_PH_RST,
                                  phase_d == WDT_PH_PEND && phase_q != WDT_PH_PEND};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_q <= '0;
    end else begin
      evt_q <= (rd_evt ? '0 : evt_q) | evt_new;
    end
  end

  // outputs registered; reset request is held until the system reset lands
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      irq_q <= int_masked || |(evt_q & evt_mask_q); // [RULE_10]
      rst_q <= phase_q == WDT_PH_RST; // [RULE_04]
    end
  end
  assign irq = irq_q;
  assign sys_reset_req = rst_q;

  // read data selection
  logic [31:0] rd_mux;
  logic rd_hit;
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (rif.rd_addr)
      WDT_LOAD_OFS: rd_mux = load_q;
      WDT_VALUE_OFS: rd_mux = count_q;
      WDT_CTRL_OFS: rd_mux = {29'h0000_0000, stall_q, rsten_q, en_q};
      WDT_INTCLR_OFS: rd_mux = 32'h0000_0000;
      WDT_RIS_OFS: rd_mux = {31'h0000_0000, int_raw}; // [RULE_11]
      WDT_MIS_OFS: rd_mux = {31'h0000_0000, int_masked}; // [RULE_11]
      WDT_LOCK_OFS: rd_mux = {31'h0000_0000, lock_q}; // [RULE_09]
      WDT_EVT_STAT_OFS: rd_mux = {30'h0000_0000, evt_q};
      WDT_EVT_MASK_OFS: rd_mux = {30'h0000_0000, evt_mask_q};
      default: rd_hit = 1'b0;
    endcase
  end
  assign rif.rd_data = rd_mux;
  assign rif.rd_ok = rd_hit;
  assign rif.wr_ok = wr_mapped;

  // checks
  sequence s_pend_zero;
    phase_q == WDT_PH_PEND && timeout && rsten_q && !wr_intclr;
  endsequence
  a_count_down: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && !at_zero && !load_upd && phase_q != WDT_PH_RST && !(phase_q == WDT_PH_PEND && wr_intclr)
    |=> count_q == $past(count_q) - 32'h0000_0001) // [RULE_01]
    else $error("counter did not decrement");
  a_first_reload: assert property (@(posedge aclk) disable iff (!aresetn)
    phase_q == WDT_PH_RUN && timeout && !load_upd |=> phase_q == WDT_PH_PEND && count_q == load_q) // [RULE_03]
    else $error("first timeout did not reload");
  a_second_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_pend_zero and !load_upd) |=> phase_q == WDT_PH_RST ##1 sys_reset_req) // [RULE_04]
    else $error("second timeout gave no reset request");
  a_clear_reload: assert property (@(posedge aclk) disable iff (!aresetn)
    phase_q == WDT_PH_PEND && wr_intclr && !timeout && !load_upd |=> !int_raw && count_q == load_q) // [RULE_05]
    else $error("clear did not reload");
  a_load_now: assert property (@(posedge aclk) disable iff (!aresetn)
    load_upd && phase_q != WDT_PH_RST |=> count_q == load_q) // [RULE_06]
    else $error("load write did not reach counter");
  a_locked_cfg: assert property (@(posedge aclk) disable iff (!aresetn)
    lock_q && !wr_lock |=> $stable(load_q) && $stable(en_q) && $stable(rsten_q)) // [RULE_08]
    else $error("configuration changed while locked");
  a_lock_read: assert property (@(posedge aclk) disable iff (!aresetn)
    rif.rd_en && rif.rd_addr == WDT_LOCK_OFS |=> s_axi_rdata == {31'h0000_0000, $past(lock_q)}) // [RULE_09]
    else $error("lock state misread");
  a_irq_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    evt_mask_q == '0 |=> irq == $past(int_masked)) // [RULE_10]
    else $error("interrupt output does not follow masked status");
  a_zero_load: assert property (@(posedge aclk) disable iff (!aresetn)
    zero_load && phase_q != WDT_PH_RST |=> int_raw) // [RULE_15]
    else $error("zero load raised no interrupt");
  a_stall_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    stall_q && dbg_halt && !rif.wr_en && phase_q != WDT_PH_PEND |=> $stable(count_q)) // [RULE_16]
    else $error("counter moved during debug halt");
  a_rst_hold: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_04]
    phase_q == WDT_PH_RST |=> phase_q == WDT_PH_RST && $stable(count_q) && sys_reset_req)
    else $error("reset request not held");
  a_lock_enable: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_07]
    lock_q && wr_ctrl && !en_q |=> !en_q)
    else $error("enable taken while locked");
  a_irq_clear: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_10]
    phase_q == WDT_PH_PEND && wr_intclr && !timeout && evt_mask_q == '0 |-> ##2 !irq)
    else $error("interrupt output stayed up after clear");
endmodule // wdt_top
`default_nettype wire
